// ===== aseq_afe_model.sv
// Behavioural holding capacitor and comparator in front of the sequencer
`timescale 1ns/1ps
`default_nettype none
module aseq_afe_model (
    // Clock
    input wire logic pclk,
    // Sequencer side
    input wire logic hold_cap_connect,
    input wire logic analog_pwr,
    input wire logic [9:0] dac_code,
    // Analog source
    input wire logic [9:0] vin,
    // Comparator
    output logic cmp_hi
);
    // ==========================================================
    // Holding capacitor
    logic [9:0] held_ff = 10'h000;
    logic tog_ff = 1'b0;
    // Tracks only while connected, so input moves after the cut cannot leak in
    always @(posedge pclk) begin
        if (hold_cap_connect) begin
            held_ff <= vin;
        end
        tog_ff <= ~tog_ff;
    end
    // Unpowered comparator gives a toggling level, never a usable answer
    assign cmp_hi = analog_pwr ? (held_ff >= dac_code) : tog_ff;
endmodule // aseq_afe_model
`default_nettype wire

// ===== aseq_defs.vh
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef ASEQ_DEFS_VH
`define ASEQ_DEFS_VH
// ==========================================================
// Register byte offsets (APB, word aligned)
// Control register two keeps its word index; its byte address is four times it
`define ASEQ_CTRL_TWO_INDEX 10'h09B
`define ASEQ_OFF_CTRL_ZERO 10'h000
`define ASEQ_OFF_CTRL_ONE 10'h004
`define ASEQ_OFF_CTRL_TWO (`ASEQ_CTRL_TWO_INDEX << 2)
`define ASEQ_OFF_RESULT_HIGH 10'h008
`define ASEQ_OFF_RESULT_LOW 10'h00C
`define ASEQ_OFF_STATUS 10'h010
// ==========================================================
// conv_ctrl_zero fields
`define ASEQ_C0_ON 0
`define ASEQ_C0_GO 2
`define ASEQ_C0_CHS_LSB 3
`define ASEQ_C0_CS_LSB 6
// conv_ctrl_one fields
`define ASEQ_C1_PCFG_LSB 0
`define ASEQ_C1_VCFG_LSB 4
`define ASEQ_C1_CS2 6
`define ASEQ_C1_FMT 7
// conv_ctrl_two field
`define ASEQ_C2_ACQ_LSB 3
// status fields
`define ASEQ_ST_FLAG 0
`define ASEQ_ST_IE 1
// ==========================================================
// Reset values
`define ASEQ_RST_C0 8'h00
`define ASEQ_RST_C1 8'h00
`define ASEQ_RST_C2 8'h00
// ==========================================================
// Timing counts
`define ASEQ_CONV_BITS 10
`define ASEQ_CONV_TADS 12
`define ASEQ_POST_TADS 2
`define ASEQ_RC_TAD_NS 4000
`define ASEQ_CLK_NS 10
`define ASEQ_RC_TAD_CYC ((`ASEQ_RC_TAD_NS) / (`ASEQ_CLK_NS))
`define ASEQ_INSTR_CLKS 4
`endif

// ===== aseq_sar.v
// Successive-approximation register, one bit decided per conversion-bit period
`timescale 1ns/1ps
`default_nettype none
module aseq_sar #(
    parameter BITS = 10
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire start,
    input wire step,
    input wire cmp_hi,
    // Trial code and result
    output reg [BITS-1:0] trial,
    output reg [BITS-1:0] code_ff
);
    // ==========================================================
    reg [BITS-1:0] mask_ff;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= {BITS{1'b0}};
            code_ff <= {BITS{1'b0}};
        end else if (start) begin
            mask_ff <= {1'b1, {(BITS-1){1'b0}}};
            code_ff <= {BITS{1'b0}};
        end else if (step && mask_ff != {BITS{1'b0}}) begin
            // Keep the trial bit if the input is above the trial level
            if (cmp_hi)
                code_ff <= code_ff | mask_ff;
            mask_ff <= mask_ff >> 1;
        end
    end
    always @* begin
        trial = code_ff | mask_ff;
    end
endmodule // aseq_sar
`default_nettype wire

// ===== aseq_tad_gen.v
// Conversion-bit period enable generator
`timescale 1ns/1ps
`default_nettype none
`include "aseq_defs.vh"
module aseq_tad_gen #(
    parameter RC_DIV = `ASEQ_RC_TAD_CYC
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire run,
    input wire [2:0] clk_sel,
    // Enable out
    output reg tad_tick
);
    // ==========================================================
    // Divider; Tosc options give 2..64 clocks, RC uses its own count
    reg [8:0] cnt_ff;
    reg [8:0] limit;
    always @* begin
        case (clk_sel)
            3'h0: limit = 9'h001;
            3'h4: limit = 9'h003;
            3'h1: limit = 9'h007;
            3'h5: limit = 9'h00F;
            3'h2: limit = 9'h01F;
            3'h6: limit = 9'h03F;
            default: limit = RC_DIV[8:0] - 9'h001;
        endcase
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 9'h000;
            tad_tick <= 1'b0;
        end else if (!run) begin
            cnt_ff <= 9'h000;
            tad_tick <= 1'b0;
        end else if (cnt_ff >= limit) begin
            cnt_ff <= 9'h000;
            tad_tick <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 9'h001;
            tad_tick <= 1'b0;
        end
    end
endmodule // aseq_tad_gen
`default_nettype wire

// ===== aseq_top.v
// Acquisition and conversion sequencer for a 10-bit SAR converter
// How it works
// - Acquisition code 0..7 inserts 0,2,4,6,8,12,16,20 bit periods before converting
// - RC clock with code zero waits one instruction cycle before the clock starts
// - Software selects supply rails or reference pins as converter reference
// - Conversion continues in sleep only with the internal RC clock
// - Ten-bit result found by successive approximation, ten steps
// - Reset restores registers, switches converter off, aborts any conversion
// - On completion load result pair, clear go/done, set done flag
// - Power-on reset leaves result pair untouched
// - Each shared pin is software selectable analog or digital
// - After conversion hold off next acquisition at least two bit periods
// - Holding capacitor stays disconnected during the post-conversion delay
// - Code zero: go/done stops sampling and converts, at once on Tosc clocks, one instruction cycle later on the RC clock
// - Nonzero code: keep sampling programmed periods, then convert automatically
// - After conversion resume sampling the selected channel
// - No status tells acquisition end from conversion start
// - Clearing go/done aborts; result keeps last completed or written value
// - A full conversion lasts at least twelve bit periods
// - Sleep with non-RC clock aborts and powers off, enable stays set
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "aseq_defs.vh"
module aseq_top #(
    parameter RC_DIV = `ASEQ_RC_TAD_CYC
) (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [9:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // System
    input wire por_event,
    input wire sleep_req,
    // Analog front end
    input wire cmp_hi,
    output reg [9:0] dac_code,
    output reg sample_en,
    output reg hold_cap_connect,
    output reg analog_pwr,
    output reg [3:0] chan_sel,
    output reg vref_pos_pin,
    output reg vref_neg_pin,
    output reg [13:0] pin_analog,
    // Interrupt request
    output reg conv_irq
);
    // ==========================================================
    // States
    localparam ST_IDLE = 3'h0;
    localparam ST_WAIT_TCY = 3'h1;
    localparam ST_ACQ = 3'h2;
    localparam ST_CONV = 3'h3;
    localparam ST_POST = 3'h4;
    // ==========================================================
    // Registers
    reg [7:0] ctrl0_ff;
    reg [7:0] ctrl1_ff;
    reg [2:0] acq_time_sel_ff;
    reg [9:0] result_ff;
    reg conv_done_flag_ff;
    reg conv_int_enable_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [4:0] nxt_tad_cnt;
    reg done_evt;
    reg [4:0] tad_cnt_ff;
    reg [1:0] tcy_cnt_ff;
    reg [1:0] por_sync_ff;
    reg [1:0] slp_sync_ff;
    reg asleep_ff;
    wire [2:0] clk_sel;
    wire rc_clk;
    wire tad_tick;
    wire [9:0] trial;
    wire [9:0] sar_code;
    wire converter_on;
    wire go_bit;
    wire wr_en;
    wire rd_en;
    wire sar_start;
    wire tad_run;
    wire slp_abort;
    // ==========================================================
    // Decoding helpers
    function [4:0] acq_tads;
        input [2:0] code;
        begin
            case (code)
                3'h0: acq_tads = 5'h00;
                3'h1: acq_tads = 5'h02;
                3'h2: acq_tads = 5'h04;
                3'h3: acq_tads = 5'h06;
                3'h4: acq_tads = 5'h08;
                3'h5: acq_tads = 5'h0C;
                3'h6: acq_tads = 5'h10;
                default: acq_tads = 5'h14;
            endcase
        end
    endfunction
    // Analog pin mask for a port configuration code
    function [13:0] pin_map;
        input [3:0] pcfg;
        reg [4:0] n;
        begin
            n = 5'h00;
            if (pcfg == 4'h0 || pcfg == 4'h1)
                n = 5'h0E;
            else
                n = 5'h0F - {1'b0, pcfg};
            pin_map = (n >= 5'h0E) ? 14'h3FFF : ((14'h0001 << n) - 14'h0001);
        end
    endfunction
    // ==========================================================
    // Field views
    assign converter_on = ctrl0_ff[`ASEQ_C0_ON];
    assign go_bit = ctrl0_ff[`ASEQ_C0_GO];
    assign clk_sel = {ctrl1_ff[`ASEQ_C1_CS2], ctrl0_ff[`ASEQ_C0_CS_LSB+1 -: 2]};
    assign rc_clk = (clk_sel[1:0] == 2'h3);
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    // Sleep only halts the converter when its clock is not the RC one
    assign slp_abort = asleep_ff && !rc_clk;
    assign sar_start = (state_ff != ST_CONV) && (nxt_state == ST_CONV);
    assign tad_run = (state_ff == ST_ACQ) || (state_ff == ST_CONV) || (state_ff == ST_POST);
    // ==========================================================
    // Synchronisers for asynchronous system events
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_sync_ff <= 2'h0;
            slp_sync_ff <= 2'h0;
            asleep_ff <= 1'b0;
        end else begin
            por_sync_ff <= {por_sync_ff[0], por_event};
            slp_sync_ff <= {slp_sync_ff[0], sleep_req};
            asleep_ff <= slp_sync_ff[1];
        end
    end
    // ==========================================================
    // Sub blocks
    aseq_tad_gen #(.RC_DIV(RC_DIV)) u_tad (
        .pclk(pclk),
        .presetn(presetn),
        .run(tad_run),
        .clk_sel(clk_sel),
        .tad_tick(tad_tick)
    );
    aseq_sar #(.BITS(`ASEQ_CONV_BITS)) u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .start(sar_start),
        .step(tad_tick && state_ff == ST_CONV && tad_cnt_ff < 5'd10),
        .cmp_hi(cmp_hi),
        .trial(trial),
        .code_ff(sar_code)
    );
    // ==========================================================
    // Sequencer
    always @* begin
        nxt_state = state_ff;
        nxt_tad_cnt = tad_cnt_ff;
        done_evt = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_tad_cnt = 5'h00;
                if (go_bit && converter_on && !slp_abort) begin
                    if (acq_time_sel_ff != 3'h0)
                        nxt_state = ST_ACQ;
                    else if (rc_clk)
                        nxt_state = ST_WAIT_TCY;
                    else
                        nxt_state = ST_CONV;
                end
            end
            ST_WAIT_TCY: begin
                if (tcy_cnt_ff == `ASEQ_INSTR_CLKS - 1)
                    nxt_state = ST_CONV;
            end
            ST_ACQ: begin
                if (tad_tick) begin
                    if (tad_cnt_ff + 5'h01 >= acq_tads(acq_time_sel_ff)) begin
                        nxt_state = ST_CONV;
                        nxt_tad_cnt = 5'h00;
                    end else begin
                        nxt_tad_cnt = tad_cnt_ff + 5'h01;
                    end
                end
            end
            ST_CONV: begin
                if (tad_tick) begin
                    if (tad_cnt_ff == `ASEQ_CONV_TADS - 1) begin
                        nxt_state = ST_POST;
                        nxt_tad_cnt = 5'h00;
                        done_evt = 1'b1;
                    end else begin
                        nxt_tad_cnt = tad_cnt_ff + 5'h01;
                    end
                end
            end
            ST_POST: begin
                if (tad_tick) begin
                    if (tad_cnt_ff == `ASEQ_POST_TADS - 1)
                        nxt_state = ST_IDLE;
                    else
                        nxt_tad_cnt = tad_cnt_ff + 5'h01;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        // Abort paths: go/done cleared, converter off, or sleep on a non-RC clock
        if ((state_ff == ST_ACQ || state_ff == ST_CONV || state_ff == ST_WAIT_TCY)
            && (!go_bit || !converter_on || slp_abort)) begin
            nxt_state = ST_POST;
            nxt_tad_cnt = 5'h00;
            done_evt = 1'b0;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            tad_cnt_ff <= 5'h00;
            tcy_cnt_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            tad_cnt_ff <= nxt_tad_cnt;
            tcy_cnt_ff <= (state_ff == ST_WAIT_TCY) ? tcy_cnt_ff + 2'h1 : 2'h0;
        end
    end
    // ==========================================================
    // Register file
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_ff <= `ASEQ_RST_C0;
            ctrl1_ff <= `ASEQ_RST_C1;
            acq_time_sel_ff <= 3'h0;
            conv_done_flag_ff <= 1'b0;
            conv_int_enable_ff <= 1'b0;
        end else begin
            if (wr_en && paddr == `ASEQ_OFF_CTRL_ZERO)
                ctrl0_ff <= pwdata[7:0];
            else if (wr_en && paddr == `ASEQ_OFF_CTRL_ONE)
                ctrl1_ff <= pwdata[7:0];
            else if (wr_en && paddr == `ASEQ_OFF_CTRL_TWO)
                acq_time_sel_ff <= pwdata[`ASEQ_C2_ACQ_LSB+2 -: 3];
            // Go/done drops on completion; the enable bit is never touched by sleep
            if (done_evt)
                ctrl0_ff[`ASEQ_C0_GO] <= 1'b0;
            if (wr_en && paddr == `ASEQ_OFF_STATUS)
                conv_int_enable_ff <= pwdata[`ASEQ_ST_IE];
            // Completion wins over a simultaneous clear
            if (done_evt)
                conv_done_flag_ff <= 1'b1;
            else if (wr_en && paddr == `ASEQ_OFF_STATUS && !pwdata[`ASEQ_ST_FLAG])
                conv_done_flag_ff <= 1'b0;
        end
    end
    // Result pair has no reset so a power-on leaves it untouched
    always @(posedge pclk) begin
        if (done_evt)
            result_ff <= sar_code;
        else if (wr_en && paddr == `ASEQ_OFF_RESULT_HIGH)
            result_ff[9:2] <= pwdata[7:0];
        else if (wr_en && paddr == `ASEQ_OFF_RESULT_LOW)
            result_ff[1:0] <= pwdata[7:6];
    end
    // ==========================================================
    // APB read path and outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (rd_en) begin
                if (paddr == `ASEQ_OFF_CTRL_ZERO)
                    prdata <= {24'h000000, ctrl0_ff};
                else if (paddr == `ASEQ_OFF_CTRL_ONE)
                    prdata <= {24'h000000, ctrl1_ff};
                else if (paddr == `ASEQ_OFF_CTRL_TWO)
                    prdata <= {26'h0000000, acq_time_sel_ff, 3'h0};
                else if (paddr == `ASEQ_OFF_RESULT_HIGH)
                    prdata <= {24'h000000, result_ff[9:2]};
                else if (paddr == `ASEQ_OFF_RESULT_LOW)
                    prdata <= {24'h000000, result_ff[1:0], 6'h00};
                else if (paddr == `ASEQ_OFF_STATUS)
                    prdata <= {30'h00000000, conv_int_enable_ff, conv_done_flag_ff};
                else begin
                    prdata <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            end
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_code <= 10'h000;
            sample_en <= 1'b0;
            hold_cap_connect <= 1'b0;
            analog_pwr <= 1'b0;
            chan_sel <= 4'h0;
            vref_pos_pin <= 1'b0;
            vref_neg_pin <= 1'b0;
            pin_analog <= 14'h3FFF;
            conv_irq <= 1'b0;
        end else begin
            dac_code <= trial;
            // Capacitor tracks the channel except while converting or settling
            sample_en <= converter_on && !slp_abort
                && (nxt_state == ST_IDLE || nxt_state == ST_ACQ
                || nxt_state == ST_WAIT_TCY);
            hold_cap_connect <= converter_on && !slp_abort
                && nxt_state != ST_POST && nxt_state != ST_CONV;
            analog_pwr <= converter_on && !slp_abort;
            chan_sel <= ctrl0_ff[`ASEQ_C0_CHS_LSB+2 -: 3] & 4'h7;
            vref_pos_pin <= ctrl1_ff[`ASEQ_C1_VCFG_LSB];
            vref_neg_pin <= ctrl1_ff[`ASEQ_C1_VCFG_LSB+1];
            pin_analog <= pin_map(ctrl1_ff[3:0]);
            conv_irq <= conv_done_flag_ff && conv_int_enable_ff;
        end
    end
endmodule // aseq_top
`default_nettype wire

// ===== aseq_top_chk.sv
// Concurrent checks on the sequencer top-level ports
`timescale 1ns/1ps
`default_nettype none
`include "aseq_defs.vh"
module aseq_top_chk #(
    parameter RC_DIV = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Analog side
    input wire logic sample_en,
    input wire logic hold_cap_connect,
    input wire logic analog_pwr,
    input wire logic vref_pos_pin,
    input wire logic vref_neg_pin,
    input wire logic [13:0] pin_analog,
    input wire logic conv_irq
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready;
        psel && !penable |=> pready && psel && penable;
    endproperty
    property p_ready_only;
        pready |-> psel && penable;
    endproperty
    property p_err;
        pslverr |-> pready && !pwrite && prdata == 32'h0;
    endproperty
    // Post delay is at least two bit periods of two clocks each
    property p_post;
        $fell(hold_cap_connect) |=> !hold_cap_connect [*3];
    endproperty
    property p_samp;
        sample_en |-> hold_cap_connect && analog_pwr;
    endproperty
    property p_cfg;
        $changed({pin_analog, vref_pos_pin, vref_neg_pin}) |->
            $past(psel && penable && pwrite && paddr == `ASEQ_OFF_CTRL_ONE, 2);
    endproperty
    property p_irq;
        $fell(conv_irq) |-> $past(psel && penable && pwrite && paddr == `ASEQ_OFF_STATUS, 2);
    endproperty
    property p_done;
        $rose(conv_irq) |-> !hold_cap_connect && !sample_en;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    a_ready_only: assert property (p_ready_only) else $error("stray ready");
    a_err: assert property (p_err) else $error("bad error answer");
    a_post: assert property (p_post) else $error("post delay too short");
    a_samp: assert property (p_samp) else $error("sampling while cut off");
    a_cfg: assert property (p_cfg) else $error("pin setup changed alone");
    a_irq: assert property (p_irq) else $error("flag dropped alone");
    a_done: assert property (p_done) else $error("done while sampling");
    c_done: cover property ($rose(conv_irq));
    c_err: cover property (pslverr);
    c_post: cover property ($fell(hold_cap_connect));
endmodule // aseq_top_chk
bind aseq_top aseq_top_chk #(.RC_DIV(RC_DIV)) i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_en(sample_en),
    .hold_cap_connect(hold_cap_connect), .analog_pwr(analog_pwr),
    .vref_pos_pin(vref_pos_pin), .vref_neg_pin(vref_neg_pin),
    .pin_analog(pin_analog), .conv_irq(conv_irq));
`default_nettype wire

// ===== tb_adc_acquisition_sequencer.sv
// Self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
`include "aseq_defs.vh"
module tb_adc_acquisition_sequencer;
    // ==========================================================
    // Signals
    localparam logic [9:0] A0 = `ASEQ_OFF_CTRL_ZERO;
    localparam logic [9:0] A1 = `ASEQ_OFF_CTRL_ONE;
    localparam logic [9:0] A2 = `ASEQ_OFF_CTRL_TWO;
    localparam logic [9:0] AH = `ASEQ_OFF_RESULT_HIGH;
    localparam logic [9:0] AL = `ASEQ_OFF_RESULT_LOW;
    localparam logic [9:0] AS = `ASEQ_OFF_STATUS;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic sleep_req = 1'b0;
    logic [9:0] vin = 10'h000;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, cmp_hi, sample_en, hold_cap_connect, analog_pwr;
    wire logic vref_pos_pin, vref_neg_pin, conv_irq;
    wire logic [9:0] dac_code;
    wire logic [3:0] chan_sel;
    wire logic [13:0] pin_analog;
    int mismatches = 0;
    int n_tests = 0;
    int tads[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int acq, tad, lo, n;
    logic [31:0] rdv;
    logic err;
    logic [9:0] v;
    always #5 pclk = ~pclk;
    // ==========================================================
    // Design and analog partner
    aseq_top #(.RC_DIV(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_event(1'b0),
        .sleep_req(sleep_req), .cmp_hi(cmp_hi), .dac_code(dac_code),
        .sample_en(sample_en), .hold_cap_connect(hold_cap_connect),
        .analog_pwr(analog_pwr), .chan_sel(chan_sel), .vref_pos_pin(vref_pos_pin),
        .vref_neg_pin(vref_neg_pin), .pin_analog(pin_analog), .conv_irq(conv_irq));
    aseq_afe_model i_afe (.pclk(pclk), .hold_cap_connect(hold_cap_connect),
        .analog_pwr(analog_pwr), .dac_code(dac_code), .vin(vin), .cmp_hi(cmp_hi));
    // ==========================================================
    // Tasks
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) mismatches++;
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Second edge lets registered outputs fed by the write settle
        @(posedge pclk);
        @(posedge pclk);
    endtask
    task automatic rc(input logic [9:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdv, exp);
    endtask
    // Power on first, go in a later write, then wait for the request line
    task automatic go_wait(input logic [7:0] c0, input logic s);
        apb(1'b1, A0, {24'h0, c0});
        apb(1'b1, A0, {24'h0, c0 | 8'h04});
        sleep_req <= s;
        n = 0;
        while (conv_irq !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) mismatches++;
    endtask
    // ==========================================================
    // Watchdog, generous against the roughly one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        final_report;
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'(pin_analog), 32'h3FFF);
        check(32'(analog_pwr), 32'h0);
        rc(A0, 32'h0);
        rc(A1, 32'h0);
        rc(A2, 32'h0);
        apb(1'b0, 10'h040, 32'h0);
        check(32'(err), 32'h1);
        check(rdv, 32'h0);
        apb(1'b1, A2, 32'hFF);
        rc(A2, 32'h38);
        for (int p = 0; p < 16; p++) begin
            apb(1'b1, A1, 32'(p) | 32'h30);
            check(32'(pin_analog), p == 0 ? 32'h3FFF : 32'h3FFF >> (p - 1));
            check(32'({vref_neg_pin, vref_pos_pin}), 32'h3);
        end
        apb(1'b1, A1, 32'h10);
        check(32'({vref_neg_pin, vref_pos_pin}), 32'h1);
        apb(1'b1, AS, 32'h2);
        // Codes 0..7 on the fastest clock, then code 0 on the RC clock
        for (int k = 0; k < 9; k++) begin
            acq = (k < 8) ? k : 0;
            tad = (k < 8) ? 2 : 4;
            lo = (tads[acq] + 12) * tad + ((k < 8) ? 0 : 4);
            v = 10'h0A5 + 10'(k * 97);
            vin <= v;
            apb(1'b1, A2, 32'(acq) << 3);
            go_wait((k < 8) ? 8'h09 : 8'hC9, 1'b0);
            check(32'(n >= lo - 2 && n <= lo + 8), 32'h1);
            check(32'(chan_sel), 32'h1);
            rc(AH, 32'(v[9:2]));
            rc(AL, {24'h0, v[1:0], 6'h00});
            rc(AS, 32'h3);
            rc(A0, (k < 8) ? 32'h09 : 32'hC9);
            check(32'(conv_irq), 32'h1);
            apb(1'b1, AS, 32'h2);
            check(32'(conv_irq), 32'h0);
        end
        vin <= 10'h3C3;
        apb(1'b1, A0, 32'h09);
        apb(1'b1, A0, 32'h0D);
        repeat (6) @(posedge pclk);
        apb(1'b1, A0, 32'h09);
        repeat (20) @(posedge pclk);
        rc(AH, 32'(v[9:2]));
        rc(AS, 32'h2);
        apb(1'b1, A0, 32'h0D);
        sleep_req <= 1'b1;
        repeat (40) @(posedge pclk);
        check(32'(analog_pwr), 32'h0);
        rc(AS, 32'h2);
        apb(1'b0, A0, 32'h0);
        check(rdv & 32'h1, 32'h1);
        sleep_req <= 1'b0;
        repeat (10) @(posedge pclk);
        vin <= 10'h2E1;
        go_wait(8'hC9, 1'b1);
        check(32'(conv_irq), 32'h1);
        sleep_req <= 1'b0;
        rc(AH, 32'hB8);
        apb(1'b1, AS, 32'h2);
        apb(1'b1, A1, 32'h1F);
        apb(1'b1, A0, 32'h0D);
        repeat (4) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'(analog_pwr), 32'h0);
        check(32'(pin_analog), 32'h3FFF);
        rc(A0, 32'h0);
        rc(A1, 32'h0);
        rc(AH, 32'hB8);
        final_report;
    end
endmodule // tb_adc_acquisition_sequencer
`default_nettype wire
